/* hdl/flvic_arb_if.sv */
`timescale 1ns/1ps
interface flvic_arb_if;
  logic [5:0]  req;
  logic [11:0] level;
  logic        valid;
  logic [2:0]  idx;
  logic [1:0]  win_level;

  modport arb (
    input  req,
    input  level,
    output valid,
    output idx,
    output win_level
  );
  modport ctl (
    output req,
    output level,
    input  valid,
    input  idx,
    input  win_level
  );
endinterface

/* hdl/flvic_arbiter.sv */
`timescale 1ns/1ps
module flvic_arbiter (
  flvic_arb_if.arb a
);

  // Highest level first, then lowest index within the level
  always_comb begin
    logic found;
    found       = 1'b0;
    a.valid     = 1'b0;
    a.idx       = 3'h0;
    a.win_level = 2'h0;
    for (int l = 3; l >= 0; l--) begin
      for (int s = 0; s < 6; s++) begin
        if (!found && a.req[s] && (a.level[2*s +: 2] == 2'(l))) begin
          found       = 1'b1;
          a.valid     = 1'b1;
          a.idx       = 3'(s);
          a.win_level = 2'(l);
        end
      end
    end
  end

endmodule

/* hdl/flvic_pkg.sv */
// Notes on behaviour
// - Global enable low suppresses all requests; high lets enabled sources request.
// - Comparator enable takes vector 33H; external 2 flag then never interrupts.
// - Priority is {high,low}: 11 highest, 10, 01, 00 lowest.
// - A lower level request never preempts a running routine.
// - Different pending levels: higher level is serviced first.
// - Equal level order: ext0 03H, t0 0BH, t1 1BH, serial 23H, 33H, 3BH.
// - External flags clear on vectoring only in edge mode; level follows pin.
// - Ext2 type 0 low level, 1 falling edge; polarity bit inverts both.
// - Ext2 flag set on active edge, cleared on service, software writable.
// - Timer overflow flag that caused the call is cleared on vectoring.
// - Serial request is receive OR transmit; neither is cleared here.
// - With comparator enabled, comparator flag drives 33H; ext2 flag kept.
// - PWM enable raises 3BH from its flag; top control bit is its low priority.
// - Software flag writes act like hardware updates in edge mode only; in level mode the pin overrides them.
// - Flags sampled at S5P2, polled next machine cycle, then call issued.
// - Call withheld while an equal or higher level routine runs.
// - Call issued only in the last machine cycle of the instruction.
// - After return or enable/priority write, one more instruction runs first; writes to the ext2 control register C0H set no guard.
// - Blocked requests are not remembered; each polling cycle starts fresh.
// - Shared ext2 high priority bit serves the comparator when it is enabled.
package flvic_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EXT0_CTRL  = 8'h88;
  localparam logic [7:0] ADDR_PRIO_HIGH  = 8'hB7;
  localparam logic [7:0] ADDR_PRIO_LOW   = 8'hB8;
  localparam logic [7:0] ADDR_EXT2_CTRL  = 8'hC0;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hE8;

  // ----------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PRIO_HIGH   = 8'h00;
  localparam logic [7:0] RST_PRIO_LOW    = 8'h00;
  localparam logic [7:0] RST_EXT2_CTRL   = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE  = 8'h00;
  localparam logic [1:0] RST_EXT0_CTRL   = 2'h0;
  localparam logic [7:0] MASK_PRIO_HIGH  = 8'hDB;
  localparam logic [7:0] MASK_PRIO_LOW   = 8'h5B;
  localparam logic [7:0] MASK_EXT2_CTRL  = 8'h8F;
  localparam logic [7:0] MASK_IRQ_ENABLE = 8'hDB;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_EN  = 7;
  localparam int BIT_CMP_EN     = 6;
  localparam int BIT_SERIAL     = 4;
  localparam int BIT_TIMER1     = 3;
  localparam int BIT_TIMER0     = 1;
  localparam int BIT_EXT0       = 0;
  localparam int BIT_SHARED     = 6;
  localparam int BIT_PWM_PRIO   = 7;
  localparam int BIT_EXT2_PRIO  = 3;
  localparam int BIT_EXT2_EN    = 2;
  localparam int BIT_EXT2_FLAG  = 1;
  localparam int BIT_EXT2_TYPE  = 0;
  localparam int BIT_EXT0_FLAG  = 1;
  localparam int BIT_EXT0_TYPE  = 0;

  // ----------------------------------------------------------------
  // Sources, in polling order
  // ----------------------------------------------------------------
  localparam int         NUM_SRC  = 6;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_T0   = 3'h1;
  localparam logic [2:0] SRC_T1   = 3'h2;
  localparam logic [2:0] SRC_SER  = 3'h3;
  localparam logic [2:0] SRC_SHR  = 3'h4;
  localparam logic [2:0] SRC_PWM  = 3'h5;

  function automatic logic [7:0] flvic_vector(input logic [2:0] idx);
    case (idx)
      SRC_EXT0: flvic_vector = 8'h03;
      SRC_T0:   flvic_vector = 8'h0B;
      SRC_T1:   flvic_vector = 8'h1B;
      SRC_SER:  flvic_vector = 8'h23;
      SRC_SHR:  flvic_vector = 8'h33;
      SRC_PWM:  flvic_vector = 8'h3B;
      default:  flvic_vector = 8'h03;
    endcase
  endfunction

endpackage

/* hdl/flvic_top.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps
module flvic_top (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       s5p2_strobe,
  input  wire logic       last_cycle,
  input  wire logic       reti_exec,
  input  wire logic       ext0_request_pin,
  input  wire logic       ext2_request_pin,
  input  wire logic       ext2_polarity_invert,
  input  wire logic       timer0_overflow_flag,
  input  wire logic       timer1_overflow_flag,
  input  wire logic       receive_done_flag,
  input  wire logic       transmit_done_flag,
  input  wire logic       comparator_event_flag,
  input  wire logic       pwm_timer_flag,
  input  wire logic       pwm_timer_irq_enable,
  output logic            irq_call,
  output logic      [7:0] irq_vector,
  output logic            timer0_flag_clear,
  output logic            timer1_flag_clear,
  output logic      [3:0] in_service
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ie;
    logic [7:0]  priority_low_bits;
    logic [7:0]  priority_high_bits;
    logic [7:0]  ext2_irq_control;
    logic [1:0]  ext0;
    logic        ext0_pin;
    logic        ext2_act;
    logic [5:0]  sample;
    logic [3:0]  active;
    logic        guard;
    logic        call;
    logic [7:0]  vector;
    logic        t0_clr;
    logic        t1_clr;
    logic [7:0]  rdata;
  } flvic_state_s;

  flvic_state_s st_q;
  flvic_state_s st_d;

  flvic_arb_if arb_if ();

  flvic_arbiter u_arb (
    .a (arb_if.arb)
  );

  // ----------------------------------------------------------------
  // Request and level forming
  // ----------------------------------------------------------------
  logic       cmp_en;
  logic       ext2_now;
  logic [5:0] req_raw;
  logic [5:0] lo_bits;
  logic [5:0] hi_bits;

  assign cmp_en = st_q.ie[flvic_pkg::BIT_CMP_EN];
  // Polarity swaps low/high level and falling/rising edge
  assign ext2_now = ext2_polarity_invert ? ext2_request_pin : ~ext2_request_pin;

  always_comb begin
    req_raw[flvic_pkg::SRC_EXT0] = st_q.ext0[flvic_pkg::BIT_EXT0_FLAG]
                                 & st_q.ie[flvic_pkg::BIT_EXT0];
    req_raw[flvic_pkg::SRC_T0]   = timer0_overflow_flag & st_q.ie[flvic_pkg::BIT_TIMER0];
    req_raw[flvic_pkg::SRC_T1]   = timer1_overflow_flag & st_q.ie[flvic_pkg::BIT_TIMER1];
    req_raw[flvic_pkg::SRC_SER]  = (receive_done_flag | transmit_done_flag)
                                 & st_q.ie[flvic_pkg::BIT_SERIAL];
    // Comparator owns the shared vector; ext2 enable is masked then
    req_raw[flvic_pkg::SRC_SHR]  = cmp_en ? comparator_event_flag
                                 : (st_q.ext2_irq_control[flvic_pkg::BIT_EXT2_FLAG]
                                    & st_q.ext2_irq_control[flvic_pkg::BIT_EXT2_EN]);
    req_raw[flvic_pkg::SRC_PWM]  = pwm_timer_flag & pwm_timer_irq_enable;
    if (!st_q.ie[flvic_pkg::BIT_GLOBAL_EN]) begin
      req_raw = 6'h00;
    end
  end

  always_comb begin
    lo_bits[0] = st_q.priority_low_bits[flvic_pkg::BIT_EXT0];
    lo_bits[1] = st_q.priority_low_bits[flvic_pkg::BIT_TIMER0];
    lo_bits[2] = st_q.priority_low_bits[flvic_pkg::BIT_TIMER1];
    lo_bits[3] = st_q.priority_low_bits[flvic_pkg::BIT_SERIAL];
    lo_bits[4] = cmp_en ? st_q.priority_low_bits[flvic_pkg::BIT_SHARED]
                        : st_q.ext2_irq_control[flvic_pkg::BIT_EXT2_PRIO];
    lo_bits[5] = st_q.ext2_irq_control[flvic_pkg::BIT_PWM_PRIO];
    hi_bits[0] = st_q.priority_high_bits[flvic_pkg::BIT_EXT0];
    hi_bits[1] = st_q.priority_high_bits[flvic_pkg::BIT_TIMER0];
    hi_bits[2] = st_q.priority_high_bits[flvic_pkg::BIT_TIMER1];
    hi_bits[3] = st_q.priority_high_bits[flvic_pkg::BIT_SERIAL];
    hi_bits[4] = st_q.priority_high_bits[flvic_pkg::BIT_SHARED];
    hi_bits[5] = st_q.priority_high_bits[flvic_pkg::BIT_PWM_PRIO];
    for (int s = 0; s < 6; s++) begin
      arb_if.level[2*s +: 2] = {hi_bits[s], lo_bits[s]};
    end
  end

  // Arbitration runs on last cycle's samples, not on live flags
  assign arb_if.req = st_q.sample;

  // ----------------------------------------------------------------
  // In-service level tracking
  // ----------------------------------------------------------------
  function automatic logic [3:0] flvic_top_level(input logic [3:0] act);
    flvic_top_level = 4'h0;
    for (int l = 0; l < 4; l++) begin
      if (act[l]) begin
        flvic_top_level = 4'h1 << l;
      end
    end
  endfunction

  logic [3:0] cur_top;
  logic       level_ok;
  logic       take;
  logic       prio_write;

  assign cur_top  = flvic_top_level(st_q.active);
  // Winner must be strictly above every running level
  assign level_ok = ((4'h1 << arb_if.win_level) > cur_top);
  assign take     = s5p2_strobe & arb_if.valid & level_ok
                  & last_cycle & ~st_q.guard;
  assign prio_write = reg_wr & ((reg_addr == flvic_pkg::ADDR_IRQ_ENABLE)
                  | (reg_addr == flvic_pkg::ADDR_PRIO_LOW)
                  | (reg_addr == flvic_pkg::ADDR_PRIO_HIGH));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.call   = 1'b0;
    st_d.t0_clr = 1'b0;
    st_d.t1_clr = 1'b0;
    st_d.rdata  = 8'h00;

    // Register writes, software flag writes included
    if (reg_wr) begin
      case (reg_addr)
        flvic_pkg::ADDR_IRQ_ENABLE: st_d.ie    = reg_wdata & flvic_pkg::MASK_IRQ_ENABLE;
        flvic_pkg::ADDR_PRIO_LOW:   st_d.priority_low_bits   = reg_wdata & flvic_pkg::MASK_PRIO_LOW;
        flvic_pkg::ADDR_PRIO_HIGH:  st_d.priority_high_bits   = reg_wdata & flvic_pkg::MASK_PRIO_HIGH;
        flvic_pkg::ADDR_EXT2_CTRL:  st_d.ext2_irq_control = reg_wdata & flvic_pkg::MASK_EXT2_CTRL;
        flvic_pkg::ADDR_EXT0_CTRL:  st_d.ext0  = reg_wdata[1:0];
        default: begin
        end
      endcase
    end

    // Vectoring clears edge flags; hardware edge set below wins over it
    if (take) begin
      st_d.call   = 1'b1;
      st_d.vector = flvic_pkg::flvic_vector(arb_if.idx);
      st_d.active = st_q.active | (4'h1 << arb_if.win_level);
      case (arb_if.idx)
        flvic_pkg::SRC_EXT0: begin
          if (st_q.ext0[flvic_pkg::BIT_EXT0_TYPE]) begin
            st_d.ext0[flvic_pkg::BIT_EXT0_FLAG] = 1'b0;
          end
        end
        flvic_pkg::SRC_T0: st_d.t0_clr = 1'b1;
        flvic_pkg::SRC_T1: st_d.t1_clr = 1'b1;
        flvic_pkg::SRC_SHR: begin
          if (!cmp_en && st_q.ext2_irq_control[flvic_pkg::BIT_EXT2_TYPE]) begin
            st_d.ext2_irq_control[flvic_pkg::BIT_EXT2_FLAG] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end else if (reti_exec) begin
      st_d.active = st_q.active & ~cur_top;
    end

    // External 0: active low pin
    if (st_q.ext0[flvic_pkg::BIT_EXT0_TYPE]) begin
      if (st_q.ext0_pin && !ext0_request_pin) begin
        st_d.ext0[flvic_pkg::BIT_EXT0_FLAG] = 1'b1;
      end
    end else begin
      st_d.ext0[flvic_pkg::BIT_EXT0_FLAG] = ~ext0_request_pin;
    end
    st_d.ext0_pin = ext0_request_pin;

    // External 2 keeps updating its flag even when the comparator owns 33H
    if (st_q.ext2_irq_control[flvic_pkg::BIT_EXT2_TYPE]) begin
      if (!st_q.ext2_act && ext2_now) begin
        st_d.ext2_irq_control[flvic_pkg::BIT_EXT2_FLAG] = 1'b1;
      end
    end else begin
      st_d.ext2_irq_control[flvic_pkg::BIT_EXT2_FLAG] = ext2_now;
    end
    st_d.ext2_act = ext2_now;

    // Fresh samples every machine cycle; nothing held over
    if (s5p2_strobe) begin
      st_d.sample = req_raw;
    end

    // Guard spans the instruction holding a return or a write to the enable, low or high priority register
    if (s5p2_strobe && last_cycle) begin
      st_d.guard = 1'b0;
    end
    if (reti_exec || prio_write) begin
      st_d.guard = 1'b1;
    end

    if (reg_rd) begin
      case (reg_addr)
        flvic_pkg::ADDR_IRQ_ENABLE: st_d.rdata = st_q.ie;
        flvic_pkg::ADDR_PRIO_LOW:   st_d.rdata = st_q.priority_low_bits;
        flvic_pkg::ADDR_PRIO_HIGH:  st_d.rdata = st_q.priority_high_bits;
        flvic_pkg::ADDR_EXT2_CTRL:  st_d.rdata = st_q.ext2_irq_control;
        flvic_pkg::ADDR_EXT0_CTRL:  st_d.rdata = {6'h00, st_q.ext0};
        default:                    st_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q          <= '0;
      st_q.ie       <= flvic_pkg::RST_IRQ_ENABLE;
      st_q.priority_low_bits      <= flvic_pkg::RST_PRIO_LOW;
      st_q.priority_high_bits      <= flvic_pkg::RST_PRIO_HIGH;
      st_q.ext2_irq_control    <= flvic_pkg::RST_EXT2_CTRL;
      st_q.ext0     <= flvic_pkg::RST_EXT0_CTRL;
      st_q.ext0_pin <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata         = st_q.rdata;
  assign irq_call          = st_q.call;
  assign irq_vector        = st_q.vector;
  assign timer0_flag_clear = st_q.t0_clr;
  assign timer1_flag_clear = st_q.t1_clr;
  assign in_service        = st_q.active;

endmodule

/* testbench/flvic_core_model.sv */
`timescale 1ns/1ps
module flvic_core_model (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic reti_req,
  output logic      s5p2_strobe,
  output logic      last_cycle,
  output logic      reti_exec
);
  // ----------------------------------------
  // Four clocks a machine cycle, two a step
  // ----------------------------------------
  logic [1:0] ph_q;
  logic       pend_q;

  assign s5p2_strobe = (ph_q == 2'h2);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph_q       <= 2'h0;
      pend_q     <= 1'b0;
      last_cycle <= 1'b0;
      reti_exec  <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) begin
        last_cycle <= ~last_cycle;
      end
      // Return kept away from the poll edge
      reti_exec <= (pend_q | reti_req) && ph_q == 2'h0;
      pend_q    <= (pend_q | reti_req) && ph_q != 2'h0;
    end
  end
endmodule

/* testbench/flvic_props.sv */
`timescale 1ns/1ps
module flvic_props (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       s5p2_strobe,
  input wire logic       last_cycle,
  input wire logic       reti_exec,
  input wire logic       irq_call,
  input wire logic [7:0] irq_vector,
  input wire logic       timer0_flag_clear,
  input wire logic       timer1_flag_clear,
  input wire logic [3:0] in_service
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  logic ea_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ea_q <= 1'b0;
    end else if (reg_wr && reg_addr == 8'hE8) begin
      ea_q <= reg_wdata[7];
    end
  end

  a_call_single:
    assert property (irq_call |=> !irq_call) else $error("call pulse too long");
  a_call_at_poll:
    assert property (irq_call |-> $past(s5p2_strobe) && $past(last_cycle))
    else $error("call outside a last-cycle poll");
  a_global_gate:
    assert property (irq_call |-> $past(ea_q)) else $error("call while disabled");
  a_t0_clear:
    assert property (timer0_flag_clear == (irq_call && irq_vector == 8'h0B))
    else $error("timer 0 clear mismatch");
  a_t1_clear:
    assert property (timer1_flag_clear == (irq_call && irq_vector == 8'h1B))
    else $error("timer 1 clear mismatch");
  a_vector_table:
    assert property (irq_call |-> irq_vector inside {8'h03, 8'h0B, 8'h1B, 8'h23,
                                                     8'h33, 8'h3B})
    else $error("illegal vector");
  a_level_above:
    assert property (irq_call |-> {1'b0, in_service} > {$past(in_service), 1'b0})
    else $error("call not above running levels");
  a_reti_release:
    assert property (reti_exec && !irq_call && in_service != 4'h0 |=>
                     $countones(in_service) == $countones($past(in_service)) - 1)
    else $error("return did not release a level");
endmodule

bind flvic_top flvic_props u_flvic_props (.*);

/* testbench/four_level_vectored_irq_controller_test.sv */
`timescale 1ns/1ps
module four_level_vectored_irq_controller_test;
  logic       clk_sys, resetn, reg_wr, reg_rd, reti_req, rd_pend;
  logic       ext0_request_pin, ext2_request_pin, ext2_polarity_invert;
  logic       timer0_overflow_flag, timer1_overflow_flag, receive_done_flag;
  logic       transmit_done_flag, comparator_event_flag, pwm_timer_flag;
  logic       pwm_timer_irq_enable, irq_call, timer0_flag_clear, timer1_flag_clear;
  logic       s5p2_strobe, last_cycle, reti_exec;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_vector, d;
  logic [3:0] in_service;
  logic [7:0] exp_vec[$];
  logic [7:0] exp_rd[$];
  int         errors, cmp_count, i;

  flvic_top        u_flvic_top (.*);
  flvic_core_model u_flvic_core_model (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Monitor: oldest note against each result
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rd_pend) check(reg_rdata, exp_rd.pop_front());
    rd_pend = (reg_rd === 1'b1);
    if (irq_call === 1'b1) begin
      // FF is no vector, so a stray call always fails
      if (exp_vec.size() == 0) check(irq_vector, 8'hFF);
      else check(irq_vector, exp_vec.pop_front());
    end
    if (timer0_flag_clear === 1'b1) timer0_overflow_flag <= 1'b0;
    if (timer1_flag_clear === 1'b1) timer1_overflow_flag <= 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task automatic reti();
    repeat (6) @(posedge clk_sys);
    reti_req <= 1'b1;
    @(posedge clk_sys);
    reti_req <= 1'b0;
  endtask

  // Waits for the call, then clears a non-timer source as software would; timer flags drop on the clear pulses
  task automatic serve(input logic [7:0] v, input bit ret);
    int n;
    exp_vec.push_back(v);
    for (n = 0; n < 400 && irq_call !== 1'b1; n++) @(posedge clk_sys);
    if (n == 400) begin
      check(8'hFF, v);
      conclude();
    end
    case (v)
      8'h03: ext0_request_pin <= 1'b1;
      8'h23: begin
        receive_done_flag  <= 1'b0;
        transmit_done_flag <= 1'b0;
      end
      8'h33: begin
        // Pin 2 back to its idle level, so a level request drops
        comparator_event_flag <= 1'b0;
        ext2_request_pin      <= ~ext2_polarity_invert;
      end
      8'h3B: pwm_timer_flag <= 1'b0;
      default: ;
    endcase
    if (ret) reti();
  endtask

  initial begin
    {resetn, reg_wr, reg_rd, reti_req, rd_pend, ext2_request_pin} = 6'h00;
    {timer0_overflow_flag, timer1_overflow_flag, receive_done_flag} = 3'h0;
    {transmit_done_flag, comparator_event_flag, pwm_timer_flag} = 3'h0;
    {ext0_request_pin, ext2_polarity_invert, pwm_timer_irq_enable} = 3'h7;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    errors    = 0;
    cmp_count = 0;
    d = 8'($urandom(32'h186C));
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    // ----------------------------------------
    // Registers: reset values, masks, hole
    // ----------------------------------------
    rd(8'h88, 8'h00);
    rd(8'hB7, 8'h00);
    rd(8'hB8, 8'h00);
    rd(8'hC0, 8'h00);
    rd(8'hE8, 8'h00);
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom());
      wr(8'hB7, d);
      rd(8'hB7, d & 8'hDB);
      wr(8'hB8, d);
      rd(8'hB8, d & 8'h5B);
      wr(8'h55, d);
      rd(8'h55, 8'h00);
    end
    wr(8'hB7, 8'h00);
    wr(8'hB8, 8'h00);
    // ----------------------------------------
    // Sources and levels
    // ----------------------------------------
    wr(8'hE8, 8'h02);
    timer0_overflow_flag <= 1'b1;
    repeat (40) @(posedge clk_sys);
    wr(8'hE8, 8'h82);
    serve(8'h0B, 1);
    wr(8'hC0, 8'h05);
    wr(8'hE8, 8'h9B);
    {ext0_request_pin, ext2_request_pin, pwm_timer_flag} <= 3'h3;
    {timer0_overflow_flag, timer1_overflow_flag, receive_done_flag} <= 3'h7;
    serve(8'h03, 1);
    serve(8'h0B, 1);
    serve(8'h1B, 1);
    serve(8'h23, 1);
    serve(8'h33, 1);
    serve(8'h3B, 1);
    rd(8'hC0, 8'h05);
    wr(8'hE8, 8'h9A);
    wr(8'hB7, 8'h10);
    transmit_done_flag <= 1'b1;
    serve(8'h23, 0);
    timer0_overflow_flag <= 1'b1;
    repeat (40) @(posedge clk_sys);
    wr(8'hB7, 8'h18);
    wr(8'hB8, 8'h08);
    timer1_overflow_flag <= 1'b1;
    serve(8'h1B, 1);
    reti();
    serve(8'h0B, 1);
    // ----------------------------------------
    // Comparator takes the shared vector
    // ----------------------------------------
    wr(8'hE8, 8'hC0);
    wr(8'hC0, 8'h07);
    comparator_event_flag <= 1'b1;
    serve(8'h33, 1);
    repeat (40) @(posedge clk_sys);
    rd(8'hC0, 8'h07);
    // ----------------------------------------
    // External 0 edge mode, external 2 low level
    // ----------------------------------------
    wr(8'hC0, 8'h01);
    wr(8'h88, 8'h01);
    wr(8'hE8, 8'h81);
    ext0_request_pin <= 1'b0;
    serve(8'h03, 1);
    rd(8'h88, 8'h01);
    {ext2_polarity_invert, ext2_request_pin} <= 2'h1;
    wr(8'hC0, 8'h04);
    ext2_request_pin <= 1'b0;
    serve(8'h33, 1);
    rd(8'hC0, 8'h04);
    repeat (10) @(posedge clk_sys);
    check({4'h0, in_service}, 8'h00);
    conclude();
  end
endmodule
